// *** hdl/aisr_pkg.sv ***
// Package with register map, field layout and encodings of the converter control.
package aisr_pkg;

    // ==========================================================================
    // Register map (word index = byte address / 4 not used: plain 8-bit port)
    // ==========================================================================
    localparam logic [3:0] ADDR_INPUT_REF_SEL = 4'h0;
    localparam logic [3:0] ADDR_RESULT_LOW    = 4'h1;
    localparam logic [3:0] ADDR_RESULT_HIGH   = 4'h2;
    localparam logic [3:0] ADDR_CTRL_STATUS   = 4'h3;

    localparam logic [7:0] INPUT_REF_SEL_RESET = 8'h00;
    localparam logic [7:0] CTRL_STATUS_RESET   = 8'h00;

    // ==========================================================================
    // Field positions
    // ==========================================================================
    localparam int REF_SEL_LSB   = 6;
    localparam int LEFT_ALIGN_B  = 5;
    localparam int CHAN_SEL_LSB  = 0;
    localparam int CTRL_START_B  = 0;
    localparam int CTRL_DONE_B   = 1;
    localparam int CTRL_BUSY_B   = 2;
    localparam int CTRL_LOCK_B   = 3;

    // ==========================================================================
    // Encodings
    // ==========================================================================
    typedef enum logic [1:0] {
        AISR_REF_PIN      = 2'h0,
        AISR_REF_SUPPLY   = 2'h1,
        AISR_REF_RESERVED = 2'h2,
        AISR_REF_INTERNAL = 2'h3
    } aisr_ref_t;

    typedef enum logic [1:0] {
        AISR_GAIN_1   = 2'h0,
        AISR_GAIN_10  = 2'h1,
        AISR_GAIN_200 = 2'h2
    } aisr_gain_t;

    typedef enum logic [1:0] {
        AISR_SRC_PIN    = 2'h0,
        AISR_SRC_BANDGAP = 2'h1,
        AISR_SRC_GROUND = 2'h2
    } aisr_src_t;

    typedef enum logic [1:0] {
        AISR_IDLE = 2'h0,
        AISR_CONV = 2'h1,
        AISR_DONE = 2'h3
    } aisr_state_t;

    localparam logic [4:0] CHAN_BANDGAP = 5'h1E;
    localparam logic [4:0] CHAN_GROUND  = 5'h1F;
    localparam logic [9:0] SE_MAX_CODE  = 10'h3FF;
    localparam logic [9:0] DIFF_MIN     = 10'h200;
    localparam logic [9:0] DIFF_MAX     = 10'h1FF;

    // Routing that the analog front end must apply for one conversion.
    typedef struct packed {
        aisr_ref_t  ref_sel;
        aisr_src_t  source;
        logic       differential;
        logic [2:0] pos_input;
        logic [2:0] neg_input;
        aisr_gain_t gain;
    } aisr_route_t;

    // Register port request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } aisr_bus_t;

endpackage : aisr_pkg

// *** hdl/aisr_ctrl.sv ***
// Input select, reference select and result formatting of the converter.
`timescale 1ns/1ps
// ==========================================================================
// Overview of operation
// (R1) Finished value appears in low and high result bytes once done is set; under the read lock the code shows it only after the high byte is read.
// (R2) Single-ended result is unsigned 10-bit, 0 is ground, 0x3FF is max.
// (R3) Differential result is two's complement from 0x200 to 0x1FF.
// (R4) Top result bit of a differential conversion is the sign.
// (R5) Reference field: 00 pin, 01 supply, 10 reserved, 11 internal 2.56V.
// (R6) Reference and channel writes during conversion take effect at the next start.
// (R7) Alignment bit 5 set gives left adjusted result, clear right adjusted.
// (R8) Alignment change shows in result bytes at once, even mid conversion.
// (R9) Codes 00000..00111 pick single-ended inputs 0..7 at unity gain.
// (R10) Codes 01000..01111 pick gained differential pairs at 10x or 200x.
// (R11) Codes 10000..10111 neg input 1; 11000..11101 neg input 2; gain 1x.
// (R12) Code 11110 routes the bandgap, code 11111 routes ground.
// (R13) Done flag sets when conversion completes and result bytes update; the code also sets it when the read lock holds the new result back.
// (R14) Reading low byte freezes result until high byte is read.
// (R15) Reference and channel settings are latched at conversion start.
// ==========================================================================
module aisr_ctrl (
    input  wire logic                  clk_sys_i,
    input  wire logic                  reset_i,
    input  wire aisr_pkg::aisr_bus_t   bus_i,
    output logic [7:0]                 rdata_o,
    input  wire logic                  conv_complete_i,
    input  wire logic [9:0]            conv_value_i,
    output aisr_pkg::aisr_route_t      route_o,
    output logic                       conv_start_o,
    output logic                       conversion_done_flag_o
);
    import aisr_pkg::*;

    // ======================================================================
    // Registers
    // ======================================================================
    logic [7:0]  input_reference_select;
    logic        conversion_done_flag;
    logic        read_lock;
    logic [9:0]  result;
    logic [9:0]  pending;
    logic        pending_valid;
    aisr_state_t state;
    aisr_route_t next_route;
    logic [15:0] view;

    wire wr_sel  = bus_i.wr && bus_i.addr == ADDR_INPUT_REF_SEL;
    wire wr_ctl  = bus_i.wr && bus_i.addr == ADDR_CTRL_STATUS;
    wire rd_low  = bus_i.rd && bus_i.addr == ADDR_RESULT_LOW;
    wire rd_high = bus_i.rd && bus_i.addr == ADDR_RESULT_HIGH;
    wire start   = wr_ctl && bus_i.wdata[CTRL_START_B] && state == AISR_IDLE;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            input_reference_select <= INPUT_REF_SEL_RESET;
        end else if (wr_sel) begin
            // Only the live copy changes; routing uses the shadow.
            input_reference_select <= bus_i.wdata; // see (R6)
        end
    end

    // ======================================================================
    // Channel decode
    // ======================================================================
    always_comb begin
        logic [4:0] ch;
        ch = input_reference_select[CHAN_SEL_LSB +: 5];
        next_route = '0;
        next_route.ref_sel =
            aisr_ref_t'(input_reference_select[REF_SEL_LSB +: 2]); // see (R5)
        case (ch[4:3])
            2'h0: begin
                next_route.pos_input = ch[2:0]; // see (R9)
            end
            2'h1: begin
                // Odd codes take the upper input of the pair; even codes
                // short both sides to the lower input to measure offset.
                next_route.differential = 1'b1; // see (R10)
                next_route.neg_input = {1'b0, ch[2], 1'b0};
                next_route.pos_input = {1'b0, ch[2], ch[0]};
                next_route.gain = ch[1] ? AISR_GAIN_200 : AISR_GAIN_10;
            end
            2'h2: begin
                next_route.differential = 1'b1; // see (R11)
                next_route.pos_input = ch[2:0];
                next_route.neg_input = 3'h1;
            end
            default: begin
                if (ch == CHAN_BANDGAP) begin
                    next_route.source = AISR_SRC_BANDGAP; // see (R12)
                end else if (ch == CHAN_GROUND) begin
                    next_route.source = AISR_SRC_GROUND; // see (R12)
                end else begin
                    next_route.differential = 1'b1; // see (R11)
                    next_route.pos_input = ch[2:0];
                    next_route.neg_input = 3'h2;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            route_o <= '0;
        end else if (start) begin
            route_o <= next_route; // see (R15) see (R6)
        end
    end

    // ======================================================================
    // Conversion sequence
    // ======================================================================
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state        <= AISR_IDLE;
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= start;
            case (state)
                AISR_IDLE: begin
                    if (start) begin
                        state <= AISR_CONV;
                    end
                end
                AISR_CONV: begin
                    if (conv_complete_i) begin
                        state <= AISR_DONE;
                    end
                end
                AISR_DONE: begin
                    state <= AISR_IDLE;
                end
                default: begin
                    state <= AISR_IDLE;
                end
            endcase
        end
    end

    // The converter delivers two's complement for differential routes and
    // unsigned otherwise; the code is stored as delivered.
    wire        capture = state == AISR_CONV && conv_complete_i;
    wire        can_upd = !read_lock || rd_high;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            result        <= '0;
            pending       <= '0;
            pending_valid <= 1'b0;
        end else if (capture && can_upd) begin
            result        <= conv_value_i; // see (R1) see (R2) see (R3)
            pending_valid <= 1'b0;
        end else if (capture) begin
            pending       <= conv_value_i; // see (R14)
            pending_valid <= 1'b1;
        end else if (pending_valid && can_upd) begin
            result        <= pending;
            pending_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            read_lock <= 1'b0;
        end else if (rd_low) begin
            read_lock <= 1'b1; // see (R14)
        end else if (rd_high) begin
            read_lock <= 1'b0;
        end
    end

    // Set wins over a software clear in the same cycle.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            conversion_done_flag <= 1'b0;
        end else if (capture) begin
            conversion_done_flag <= 1'b1; // see (R13)
        end else if (wr_ctl && bus_i.wdata[CTRL_DONE_B]) begin
            conversion_done_flag <= 1'b0;
        end
    end
    assign conversion_done_flag_o = conversion_done_flag;

    // ======================================================================
    // Read port
    // ======================================================================
    always_comb begin
        if (input_reference_select[LEFT_ALIGN_B]) begin
            view = {result, 6'h00}; // see (R7) see (R8)
        end else begin
            view = {6'h00, result}; // see (R7)
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                ADDR_INPUT_REF_SEL: rdata_o <= input_reference_select;
                ADDR_RESULT_LOW:    rdata_o <= view[7:0];
                ADDR_RESULT_HIGH:   rdata_o <= view[15:8]; // see (R4)
                ADDR_CTRL_STATUS:   rdata_o <= {4'h0, read_lock,
                                        state != AISR_IDLE,
                                        conversion_done_flag, 1'b0};
                default:            rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    sequence conv_ends;
        state == AISR_CONV && conv_complete_i;
    endsequence

    // A start pulse longer than one cycle would restart the core.
    sequence start_pulse;
        conv_start_o ##1 !conv_start_o;
    endsequence

    // A result that arrives between the two byte reads has to wait.
    sequence held_capture;
        state == AISR_CONV && conv_complete_i && read_lock && !rd_high;
    endsequence

    wire [4:0] chan_code = input_reference_select[CHAN_SEL_LSB +: 5];

    route_held_a: assert property ( // see (R6)
        @(posedge clk_sys_i) disable iff (reset_i)
        state == AISR_CONV |=> $stable(route_o))
        else $error("Routing changed during a conversion.");

    done_sets_a: assert property ( // see (R13)
        @(posedge clk_sys_i) disable iff (reset_i)
        conv_ends |=> conversion_done_flag)
        else $error("Done flag not set after completion.");

    result_store_a: assert property ( // see (R1)
        @(posedge clk_sys_i) disable iff (reset_i)
        conv_ends ##0 !read_lock |=> result == $past(conv_value_i))
        else $error("Result not stored on completion.");

    lock_holds_a: assert property ( // see (R14)
        @(posedge clk_sys_i) disable iff (reset_i)
        read_lock && !rd_high |=> $stable(result))
        else $error("Result changed while low byte read pending.");

    left_view_a: assert property ( // see (R7)
        @(posedge clk_sys_i) disable iff (reset_i)
        rd_high && input_reference_select[LEFT_ALIGN_B]
        |=> rdata_o == $past(result[9:2]))
        else $error("Left adjusted high byte wrong.");

    right_view_a: assert property ( // see (R7)
        @(posedge clk_sys_i) disable iff (reset_i)
        rd_high && !input_reference_select[LEFT_ALIGN_B]
        |=> rdata_o == {6'h00, $past(result[9:8])})
        else $error("Right adjusted high byte wrong.");

    start_latch_a: assert property ( // see (R15)
        @(posedge clk_sys_i) disable iff (reset_i)
        start |=> route_o == $past(next_route))
        else $error("Settings not latched at start.");

    gnd_route_a: assert property ( // see (R12)
        @(posedge clk_sys_i) disable iff (reset_i)
        start && chan_code == CHAN_GROUND
        |=> route_o.source == AISR_SRC_GROUND)
        else $error("Ground code not routed.");

    start_pulse_a: assert property ( // see (R15)
        @(posedge clk_sys_i) disable iff (reset_i)
        start |=> start_pulse)
        else $error("Start pulse not one cycle long.");

    busy_refuse_a: assert property ( // see (R6)
        @(posedge clk_sys_i) disable iff (reset_i)
        wr_ctl && bus_i.wdata[CTRL_START_B] && state != AISR_IDLE
        |=> !conv_start_o)
        else $error("Start accepted while busy.");

    done_clear_a: assert property ( // see (R13)
        @(posedge clk_sys_i) disable iff (reset_i)
        wr_ctl && bus_i.wdata[CTRL_DONE_B] && !capture
        |=> !conversion_done_flag)
        else $error("Done flag not cleared by software.");

    lock_set_a: assert property ( // see (R14)
        @(posedge clk_sys_i) disable iff (reset_i)
        rd_low |=> read_lock)
        else $error("Low byte read did not lock the result.");

    lock_free_a: assert property ( // see (R14)
        @(posedge clk_sys_i) disable iff (reset_i)
        rd_high |=> !read_lock)
        else $error("High byte read did not unlock the result.");

    held_keep_a: assert property ( // see (R14)
        @(posedge clk_sys_i) disable iff (reset_i)
        held_capture |=> pending_valid && pending == $past(conv_value_i))
        else $error("Result arriving under lock was lost.");

    held_apply_a: assert property ( // see (R14)
        @(posedge clk_sys_i) disable iff (reset_i)
        pending_valid && rd_high && !capture
        |=> result == $past(pending))
        else $error("Held result not applied at high byte read.");

    ref_route_a: assert property ( // see (R5)
        @(posedge clk_sys_i) disable iff (reset_i)
        start
        |=> route_o.ref_sel == $past(input_reference_select[7:6]))
        else $error("Reference selection not latched.");

    se_route_a: assert property ( // see (R9)
        @(posedge clk_sys_i) disable iff (reset_i)
        start && chan_code[4:3] == 2'h0 |=> !route_o.differential
        && route_o.pos_input == $past(chan_code[2:0]))
        else $error("Single-ended input not routed.");

    pair_route_a: assert property ( // see (R10)
        @(posedge clk_sys_i) disable iff (reset_i)
        start && chan_code[4:3] == 2'h1 |=> route_o.differential
        && route_o.neg_input == {1'b0, $past(chan_code[2]), 1'b0})
        else $error("Gained pair negative input wrong.");

    neg_one_a: assert property ( // see (R11)
        @(posedge clk_sys_i) disable iff (reset_i)
        start && chan_code[4:3] == 2'h2
        |=> route_o.neg_input == 3'h1 && route_o.gain == AISR_GAIN_1)
        else $error("Negative input one not routed.");

    neg_two_a: assert property ( // see (R11)
        @(posedge clk_sys_i) disable iff (reset_i)
        start && chan_code[4:3] == 2'h3 && chan_code[4:1] != 4'hF
        |=> route_o.neg_input == 3'h2)
        else $error("Negative input two not routed.");

    gap_route_a: assert property ( // see (R12)
        @(posedge clk_sys_i) disable iff (reset_i)
        start && chan_code == CHAN_BANDGAP
        |=> route_o.source == AISR_SRC_BANDGAP)
        else $error("Bandgap code not routed.");

    low_left_a: assert property ( // see (R7)
        @(posedge clk_sys_i) disable iff (reset_i)
        rd_low && input_reference_select[LEFT_ALIGN_B]
        |=> rdata_o == {$past(result[1:0]), 6'h00})
        else $error("Left adjusted low byte wrong.");

endmodule : aisr_ctrl

// *** sim/aisr_analog_model.sv ***
// Behavioural model of the analog core that answers conversion starts.
`timescale 1ns/1ps
// ==========================================================================
// Analog core model
// ==========================================================================
module aisr_analog_model (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic       conv_start_i,
    input  wire logic [7:0] latency_i,
    input  wire logic [9:0] sample_i,
    output logic            conv_complete_o,
    output logic [9:0]      conv_value_o
);
    logic [7:0] remain;

    // The value toggles outside the completion cycle, so a design that
    // samples it at the wrong moment stores a wrong code.
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            remain          <= 8'h00;
            conv_complete_o <= 1'b0;
            conv_value_o    <= 10'h2AA;
        end else begin
            conv_complete_o <= 1'b0;
            conv_value_o    <= ~conv_value_o;
            if (conv_start_i) begin
                remain <= latency_i;
            end else if (remain != 8'h00) begin
                remain <= remain - 8'h01;
                if (remain == 8'h01) begin
                    conv_complete_o <= 1'b1;
                    conv_value_o    <= sample_i;
                end
            end
        end
    end
endmodule : aisr_analog_model

// *** sim/aisr_ctrl_tb_top.sv ***
// Self-checking testbench of the converter input select and result format.
`timescale 1ns/1ps
module aisr_ctrl_tb_top;
    import aisr_pkg::*;
    logic        clk_sys_i;
    logic        reset_i;
    aisr_bus_t   bus;
    logic [7:0]  rdata;
    logic        complete;
    logic [9:0]  value;
    aisr_route_t route;
    logic        start;
    logic        done_flag;
    logic [7:0]  latency;
    logic [9:0]  sample;
    int          errors;
    int          checks;

    aisr_ctrl uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_i(bus),
        .rdata_o(rdata), .conv_complete_i(complete), .conv_value_i(value),
        .route_o(route), .conv_start_o(start),
        .conversion_done_flag_o(done_flag));
    aisr_analog_model core (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .conv_start_i(start), .latency_i(latency), .sample_i(sample),
        .conv_complete_o(complete), .conv_value_o(value));

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    // ======================================================================
    // Access tasks
    // ======================================================================
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i);
        bus <= '0;
        #1;
    endtask : wr
    task automatic rchk(input string what, input logic [3:0] a,
                        input logic [7:0] exp, input logic [7:0] mask);
        @(posedge clk_sys_i);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys_i);
        bus <= '0;
        #1;
        chk(what, exp, rdata & mask);
    endtask : rchk
    // Starts a conversion and checks the routing latched for it.
    task automatic begin_conv(input logic [7:0] sel, input logic [9:0] val,
                              input logic [7:0] lat);
        logic [4:0] c;
        logic       dif;
        c = sel[4:0];
        dif = (c[4:3] != 2'b00) && (c[4:1] != 4'hF);
        sample <= val;
        latency <= lat;
        wr(ADDR_INPUT_REF_SEL, sel);
        wr(ADDR_CTRL_STATUS, 8'h01);
        chk("start", 8'h01, {7'h0, start});
        chk("ref", 8'(sel[7:6]), 8'(route.ref_sel));
        chk("diff", {7'h0, dif}, {7'h0, route.differential});
        if (c == CHAN_BANDGAP) begin
            chk("src", 8'(AISR_SRC_BANDGAP), 8'(route.source));
        end else if (c == CHAN_GROUND) begin
            chk("src", 8'(AISR_SRC_GROUND), 8'(route.source));
        end else begin
            chk("src", 8'(AISR_SRC_PIN), 8'(route.source));
            chk("pos", (c[4:3] == 2'b01) ? {6'h0, c[2], c[0]} : 8'(c[2:0]),
                8'(route.pos_input));
            chk("gain", (c[4:3] != 2'b01) ? 8'(AISR_GAIN_1) : (c[1] ?
                8'(AISR_GAIN_200) : 8'(AISR_GAIN_10)),
                8'(route.gain));
        end
        if (dif) begin
            chk("neg", c[4] ? (c[3] ? 8'h02 : 8'h01) : {6'h0, c[2], 1'b0},
                8'(route.neg_input));
        end
    endtask : begin_conv
    task automatic wait_done();
        for (int n = 0; n < 100 && done_flag !== 1'b1; n++) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk("done out", 8'h01, {7'h0, done_flag});
        rchk("done bit", ADDR_CTRL_STATUS, 8'h02, 8'h02);
        wr(ADDR_CTRL_STATUS, 8'h02);
        chk("done clear", 8'h00, {7'h0, done_flag});
    endtask : wait_done

    task automatic summarize();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        errors++;
        summarize();
    end

    // ======================================================================
    // Test sequence
    // ======================================================================
    initial begin
        errors = 0;
        checks = 0;
        bus = '0;
        reset_i = 1'b1;
        sample = 10'h000;
        latency = 8'h01;
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rchk("sel reset", ADDR_INPUT_REF_SEL, INPUT_REF_SEL_RESET, 8'hFF);
        rchk("unmapped", 4'hF, 8'h00, 8'hFF);
        // Every channel code, reference code cycling, prompt and slow core.
        for (int i = 0; i < 32; i++) begin
            begin_conv(8'({i[1:0], 1'b0, i[4:0]}), 10'(i * 33),
                       8'(1 + (i % 4) * 5));
            wait_done();
        end
        begin_conv(8'hED, 10'h270, 8'd20);
        wr(ADDR_CTRL_STATUS, 8'h01);
        chk("busy start", 8'h00, {7'h0, start});
        rchk("busy bit", ADDR_CTRL_STATUS, 8'h04, 8'h04);
        wr(ADDR_INPUT_REF_SEL, 8'h61);
        chk("ref held", 8'h03, 8'(route.ref_sel));
        chk("pos held", 8'h03, 8'(route.pos_input));
        wait_done();
        chk("pos after", 8'h03, 8'(route.pos_input));
        rchk("low left", ADDR_RESULT_LOW, 8'h00, 8'hFF);
        rchk("high left", ADDR_RESULT_HIGH, 8'h9C, 8'hFF);
        wr(ADDR_INPUT_REF_SEL, 8'hCD);
        rchk("low right", ADDR_RESULT_LOW, 8'h70, 8'hFF);
        rchk("sign", ADDR_RESULT_HIGH, 8'h02, 8'hFF);
        rchk("low lock", ADDR_RESULT_LOW, 8'h70, 8'hFF);
        rchk("lock bit", ADDR_CTRL_STATUS, 8'h08, 8'h08);
        begin_conv(8'h40, 10'h3FF, 8'd20);
        wr(ADDR_INPUT_REF_SEL, 8'h60);
        rchk("high realign", ADDR_RESULT_HIGH, 8'h9C, 8'hFF);
        wait_done();
        rchk("low max", ADDR_RESULT_LOW, 8'hC0, 8'hFF);
        begin_conv(8'h20, 10'h000, 8'h03);
        wait_done();
        rchk("high held", ADDR_RESULT_HIGH, 8'hFF, 8'hFF);
        rchk("low zero", ADDR_RESULT_LOW, 8'h00, 8'hFF);
        rchk("high zero", ADDR_RESULT_HIGH, 8'h00, 8'hFF);
        summarize();
    end
endmodule : aisr_ctrl_tb_top
